// File: dv/ivas_cpu_model.sv
`timescale 1ns/1ps
// Processor side of the system bus, plus the external delay line on the light strobe copy
module ivas_cpu_model (
    input  wire logic clock,
    input  wire logic ras_copy_n,
    input  wire logic data_ready,
    input  wire logic instr_ready,
    output logic      req_valid,
    output logic      req_sel,
    output logic      req_write,
    output logic      req_instr,
    output logic      req_burst,
    output logic      write_slow,
    output logic      dly_tap
);
    // Short delay so the mux switch still lands inside the row cycle at this clock
    assign #3 dly_tap = ~ras_copy_n;

    initial begin
        {req_valid, req_sel, req_write, req_instr, req_burst, write_slow} = 6'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Entered at a falling edge; request held for nw falling edges after its ready
    task automatic access(input logic sel, input ivas_pkg::ivas_kind_t kind, input logic slow,
                          input int nw, output int cyc, output int words);
        cyc = 1;
        words = 0;
        // Lines the controller ignores for this kind carry the slow bit, so they vary too
        {req_valid, req_sel, req_write, req_instr, req_burst, write_slow} = {1'b1, sel,
            (kind == ivas_pkg::KIND_WRITE) || (kind == ivas_pkg::KIND_INSTR && slow),
            kind == ivas_pkg::KIND_INSTR, (kind == ivas_pkg::KIND_INSTR) || slow, slow};
        do begin
            @(negedge clock);
            cyc++;
        end while (data_ready !== 1'b1 && instr_ready !== 1'b1 && cyc < 40);
        for (int i = 0; i < nw; i++) begin
            words += int'(instr_ready === 1'b1);
            @(negedge clock);
        end
    endtask : access

    // Valid and burst drop; write and instruction lines flip so a stale value never looks held
    task automatic idle(input int n);
        {req_valid, req_burst, req_write, req_instr} = {2'h0, ~req_write, ~req_instr};
        repeat (n) @(negedge clock);
    endtask : idle
endmodule : ivas_cpu_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic resp_in = 1'b0;
    logic req_valid, req_sel, req_write, req_instr, req_burst, write_slow, dly_tap;
    logic ras_n, ras_copy_n, mux_col, cas_n, we_n, tr_n, data_ready, instr_ready, resp_out;
    logic [1:0] serial_shift_clock, bank_oe, prev_sas, prev_oe;
    logic prev_ras, prev_cas;
    logic [31:0] seed, mseed;
    int failures, checks_done, ras_falls, c, w, f0;

    always #5 clock = ~clock;

    ivas_seq #(.NUM_BANKS(2)) uut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_sel(req_sel),
        .req_write(req_write), .req_instr(req_instr), .req_burst(req_burst), .write_slow(write_slow),
        .dly_tap(dly_tap), .resp_in(resp_in), .ras_n(ras_n), .ras_copy_n(ras_copy_n), .mux_col(mux_col),
        .cas_n(cas_n), .we_n(we_n), .tr_n(tr_n), .serial_shift_clock(serial_shift_clock), .bank_oe(bank_oe), .data_ready(data_ready),
        .instr_ready(instr_ready), .resp_out(resp_out));

    ivas_cpu_model cpu (.clock(clock), .ras_copy_n(ras_copy_n), .data_ready(data_ready),
        .instr_ready(instr_ready), .req_valid(req_valid), .req_sel(req_sel), .req_write(req_write),
        .req_instr(req_instr), .req_burst(req_burst), .write_slow(write_slow), .dly_tap(dly_tap));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int exp_cyc(input ivas_pkg::ivas_kind_t k, input logic slow);
        return (k == ivas_pkg::KIND_INSTR) ? 6 : (k == ivas_pkg::KIND_WRITE) ? (slow ? 4 : 3) : 5;
    endfunction : exp_cyc

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // Per-cycle watch on the strobes and responses, sampled where they have settled
    always @(negedge clock) begin
        if (!rst) begin
            check("resp_out", resp_out, data_ready | instr_ready | resp_in);
            check("ras copy", ras_copy_n, ras_n);
            if (ras_n === 1'b0 && prev_ras === 1'b1) begin
                ras_falls++;
                check("mux_col in row cycle", mux_col, 1'b1);
                check("cas_n in row cycle", cas_n, 1'b1);
                check("we_n in row cycle", we_n, !(req_write && !req_instr));
                check("tr_n in row cycle", tr_n, !req_instr);
            end
            if (ras_n === 1'b1) begin
                check("mux_col while row idle", mux_col, 1'b0);
                check("we_n while row idle", we_n, 1'b1);
                check("tr_n while row idle", tr_n, 1'b1);
            end
            if (cas_n === 1'b0 && prev_cas === 1'b1) check("ras_n under column strobe", ras_n, 1'b0);
            if (prev_sas !== 2'h0) check("bank_oe after shift", bank_oe, prev_sas);
            if (bank_oe !== 2'h0 && prev_oe !== 2'h0) check("bank order", bank_oe, {prev_oe[0], prev_oe[1]});
        end
        {prev_ras, prev_cas, prev_sas, prev_oe} = {ras_n, cas_n, serial_shift_clock, bank_oe};
        mseed = lfsr(mseed);
        resp_in <= mseed[5];
    end

    initial begin
        #500000;
        failures++;
        stop_test();
    end

    initial begin
        {failures, checks_done, ras_falls} = '0;
        seed = 32'h176bf724;
        mseed = 32'h176bf724;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        cpu.idle(2);
        f0 = ras_falls;
        cpu.access(1'b0, ivas_pkg::KIND_READ, 1'b0, 0, c, w);
        check("unselected no ready", c, 40);
        check("unselected no row strobe", ras_falls, f0);
        cpu.idle(5);
        cpu.access(1'b1, ivas_pkg::KIND_READ, 1'b0, 1, c, w);
        check("read cycles", c, 5);
        cpu.access(1'b1, ivas_pkg::KIND_READ, 1'b0, 1, c, w);
        check("read in second precharge", c, 6);
        cpu.idle(5);
        cpu.access(1'b1, ivas_pkg::KIND_WRITE, 1'b0, 1, c, w);
        check("fast write cycles", c, 3);
        cpu.access(1'b1, ivas_pkg::KIND_WRITE, 1'b1, 1, c, w);
        check("write in precharge bound", c <= 6, 1);
        cpu.access(1'b1, ivas_pkg::KIND_READ, 1'b0, 1, c, w);
        check("read after write bound", c <= 8, 1);
        cpu.idle(5);
        cpu.access(1'b1, ivas_pkg::KIND_WRITE, 1'b1, 1, c, w);
        cpu.access(1'b1, ivas_pkg::KIND_INSTR, 1'b0, 4, c, w);
        check("instr after write bound", c <= 9, 1);
        check("burst words", w, 4);
        cpu.idle(5);
        cpu.access(1'b1, ivas_pkg::KIND_READ, 1'b0, 1, c, w);
        cpu.access(1'b1, ivas_pkg::KIND_INSTR, 1'b0, 2, c, w);
        check("instr after read bound", c <= 7, 1);
        cpu.idle(5);
        for (int i = 0; i < 30; i++) begin
            ivas_pkg::ivas_kind_t k;
            int nw;
            logic sel;
            seed = lfsr(seed);
            k = ivas_pkg::ivas_kind_t'(2'(seed % 3));
            nw = (k == ivas_pkg::KIND_INSTR) ? 2 + int'(seed[7:4] % 6) : 1;
            sel = (seed[12:10] != 3'h0);
            f0 = ras_falls;
            cpu.access(sel, k, seed[9], nw, c, w);
            check("access cycles", c, sel ? exp_cyc(k, seed[9]) : 40);
            check("burst words", w, (sel && k == ivas_pkg::KIND_INSTR) ? nw : 0);
            check("row strobe per access", ras_falls - f0, int'(sel));
            cpu.idle(5);
        end
        stop_test();
    end
endmodule : tb_top

// File: rtl/ivas_bank.sv
`timescale 1ns/1ps
// Serial port of one interleaved bank: shift clock, then word on the bus next cycle
module ivas_bank (
    input  wire logic  clock,
    input  wire logic  rst,
    ivas_bank_if.bank  port
);
    logic sas_q;
    logic sas_d;
    logic drive_q;
    logic drive_d;

    always_comb begin
        sas_d   = port.shift_req;
        drive_d = sas_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sas_q   <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            sas_q   <= sas_d;
            drive_q <= drive_d;
        end
    end

    assign port.serial_shift_clock   = sas_q;
    assign port.drive = drive_q;

    chk_burst_two_cycle : assert property (@(posedge clock) disable iff (rst)
        $rose(sas_q) |=> drive_q ##1 (drive_q == $past(sas_q)))
        else $error("bank word not valid in second cycle of its access");

endmodule : ivas_bank

// File: rtl/ivas_bank_if.sv
`timescale 1ns/1ps
interface ivas_bank_if;
    logic shift_req;
    logic serial_shift_clock;
    logic drive;
    modport ctl  (output shift_req, input serial_shift_clock, input drive);
    modport bank (input shift_req, output serial_shift_clock, output drive);
endinterface : ivas_bank_if

// File: rtl/ivas_cfg.svh
`ifndef IVAS_CFG_SVH
`define IVAS_CFG_SVH

// Precharge cycles after the data response of a read or a write
// Read precharge kept short so a fetch arriving next stays within seven cycles
`define IVAS_PRE_RD     3'h2
`define IVAS_PRE_WR     3'h3
`define IVAS_PRE_W      3
// Cycles from the row strobe to the first serial shift clock
`define IVAS_TR_CYCLES  3

`endif

// File: rtl/ivas_pkg.sv
package ivas_pkg;

    typedef enum logic [11:0] {
        ST_IDLE  = 12'h001,
        ST_HOLD  = 12'h002,
        ST_ROW   = 12'h004,
        ST_COL   = 12'h008,
        ST_WAIT  = 12'h010,
        ST_RDY   = 12'h020,
        ST_TR2   = 12'h040,
        ST_TR3   = 12'h080,
        ST_SHIFT = 12'h100,
        ST_BURST = 12'h200,
        ST_PRE   = 12'h400
    } ivas_state_t;

    typedef enum logic [1:0] {
        KIND_READ  = 2'h0,
        KIND_WRITE = 2'h1,
        KIND_INSTR = 2'h2
    } ivas_kind_t;

endpackage : ivas_pkg

// File: rtl/ivas_seq.sv
`timescale 1ns/1ps
`include "ivas_cfg.svh"
// Notes on behaviour
// - Decode one cycle; load row strobe if selected
// - Row strobe first, mux to column later
// - Column strobe starts read or performs write
// - Burst word valid the cycle after shift
// - Banks alternate, one burst word per cycle
// - Data read takes five cycles
// - Read arriving in second precharge: six cycles
// - Write ready two or three after decode
// - Write during write precharge: up to six
// - Read after write precharge: up to eight
// - Initial instruction access takes six cycles
// - Instruction in precharge: nine or seven
// - Responses valid every cycle, ORed across blocks
// - Light strobe copy times the mux switch
// - Column address settles before column strobe
// - Read ready two cycles after column state
module ivas_seq #(
    parameter int NUM_BANKS = 2
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 req_valid,
    input  wire logic                 req_sel,
    input  wire logic                 req_write,
    input  wire logic                 req_instr,
    input  wire logic                 req_burst,
    input  wire logic                 write_slow,
    input  wire logic                 dly_tap,
    input  wire logic                 resp_in,
    output logic                      ras_n,
    output logic                      ras_copy_n,
    output logic                      mux_col,
    output logic                      cas_n,
    output logic                      we_n,
    output logic                      tr_n,
    output logic [NUM_BANKS-1:0]      serial_shift_clock,
    output logic [NUM_BANKS-1:0]      bank_oe,
    output logic                      data_ready,
    output logic                      instr_ready,
    output logic                      resp_out
);

    ////////////////////////////////////////////////////////////////////////////
    ivas_pkg::ivas_state_t state_q;
    ivas_pkg::ivas_state_t state_d;
    ivas_pkg::ivas_kind_t  kind_q;
    ivas_pkg::ivas_kind_t  kind_d;
    logic [2:0]            pc_q;
    logic [2:0]            pc_d;
    logic                  phase_q;
    logic                  phase_d;
    logic                  ras_n_q;
    logic                  ras_n_d;
    logic                  cas_n_q;
    logic                  cas_n_d;
    logic                  tr_n_q;
    logic                  tr_n_d;
    logic                  we_n_q;
    logic                  we_n_d;
    logic                  accept;
    logic [NUM_BANKS-1:0]  shift_req;
    logic [NUM_BANKS-1:0]  drive;

    function automatic logic holds_row(input ivas_pkg::ivas_state_t s);
        holds_row = (s == ivas_pkg::ST_ROW) || (s == ivas_pkg::ST_COL) ||
                    (s == ivas_pkg::ST_WAIT) || (s == ivas_pkg::ST_RDY) ||
                    (s == ivas_pkg::ST_TR2) || (s == ivas_pkg::ST_TR3) ||
                    (s == ivas_pkg::ST_SHIFT) || (s == ivas_pkg::ST_BURST);
    endfunction : holds_row

    function automatic ivas_pkg::ivas_kind_t decode_kind(input logic wr, input logic ins);
        if (ins) begin
            decode_kind = ivas_pkg::KIND_INSTR;
        end else if (wr) begin
            decode_kind = ivas_pkg::KIND_WRITE;
        end else begin
            decode_kind = ivas_pkg::KIND_READ;
        end
    endfunction : decode_kind

    // Request held by the processor until its ready, so no capture needed
    assign accept = req_valid && req_sel;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        pc_d    = (pc_q != 3'h0) ? pc_q - 3'h1 : 3'h0;
        phase_d = phase_q;
        case (state_q)
            ivas_pkg::ST_IDLE: begin
                if (accept) begin
                    kind_d  = decode_kind(req_write, req_instr);
                    state_d = ivas_pkg::ST_ROW;
                end
            end
            ivas_pkg::ST_PRE: begin
                // Decode overlaps precharge; the row cycle waits for it to end
                if (accept) begin
                    kind_d  = decode_kind(req_write, req_instr);
                    state_d = (pc_d == 3'h0) ? ivas_pkg::ST_ROW : ivas_pkg::ST_HOLD;
                end else if (pc_d == 3'h0) begin
                    state_d = ivas_pkg::ST_IDLE;
                end
            end
            ivas_pkg::ST_HOLD: begin
                if (pc_d == 3'h0) begin
                    state_d = ivas_pkg::ST_ROW;
                end
            end
            ivas_pkg::ST_ROW: begin
                state_d = (kind_q == ivas_pkg::KIND_INSTR) ? ivas_pkg::ST_TR2 : ivas_pkg::ST_COL;
            end
            ivas_pkg::ST_COL: begin
                if (kind_q == ivas_pkg::KIND_WRITE && !write_slow) begin
                    state_d = ivas_pkg::ST_PRE;
                    pc_d    = `IVAS_PRE_WR;
                end else begin
                    state_d = ivas_pkg::ST_WAIT;
                end
            end
            ivas_pkg::ST_WAIT: begin
                if (kind_q == ivas_pkg::KIND_WRITE) begin
                    state_d = ivas_pkg::ST_PRE;
                    pc_d    = `IVAS_PRE_WR;
                end else begin
                    state_d = ivas_pkg::ST_RDY;
                end
            end
            ivas_pkg::ST_RDY: begin
                state_d = ivas_pkg::ST_PRE;
                pc_d    = `IVAS_PRE_RD;
            end
            ivas_pkg::ST_TR2: begin
                state_d = ivas_pkg::ST_TR3;
            end
            ivas_pkg::ST_TR3: begin
                state_d = ivas_pkg::ST_SHIFT;
            end
            ivas_pkg::ST_SHIFT: begin
                state_d = ivas_pkg::ST_BURST;
                phase_d = 1'b1;
            end
            ivas_pkg::ST_BURST: begin
                phase_d = ~phase_q;
                if (!req_burst) begin
                    state_d = ivas_pkg::ST_PRE;
                    pc_d    = `IVAS_PRE_RD;
                end
            end
            default: begin
                state_d = ivas_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes are registered from the next state so they switch at the edge
    always_comb begin
        ras_n_d = !holds_row(state_d);
        cas_n_d = !(state_d == ivas_pkg::ST_COL || state_d == ivas_pkg::ST_WAIT ||
                    state_d == ivas_pkg::ST_RDY);
        we_n_d  = !(kind_d == ivas_pkg::KIND_WRITE && holds_row(state_d));
        // Transfer ends a cycle before the first shift for its setup time
        tr_n_d  = !(state_d == ivas_pkg::ST_ROW || state_d == ivas_pkg::ST_TR2) ||
                  (kind_d != ivas_pkg::KIND_INSTR);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ivas_pkg::ST_IDLE;
            kind_q  <= ivas_pkg::KIND_READ;
            pc_q    <= 3'h0;
            phase_q <= 1'b0;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            we_n_q  <= 1'b1;
            tr_n_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            kind_q  <= kind_d;
            pc_q    <= pc_d;
            phase_q <= phase_d;
            ras_n_q <= ras_n_d;
            cas_n_q <= cas_n_d;
            we_n_q  <= we_n_d;
            tr_n_q  <= tr_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            ivas_bank_if bif ();
            assign bif.shift_req = (state_d == ivas_pkg::ST_SHIFT && b == 0) ||
                                   (state_d == ivas_pkg::ST_BURST && phase_d == 1'(b));
            assign shift_req[b]  = bif.shift_req;
            assign serial_shift_clock[b]        = bif.serial_shift_clock;
            assign drive[b]      = bif.drive;
            ivas_bank u_bank (
                .clock (clock),
                .rst   (rst),
                .port  (bif.bank)
            );
        end
    endgenerate

    // Copy not loaded by the array, so the delay line sees an early clean edge
    assign ras_n      = ras_n_q;
    assign ras_copy_n = ras_n_q;
    assign mux_col    = !ras_n_q && dly_tap;
    assign cas_n      = cas_n_q;
    assign we_n       = we_n_q;
    assign tr_n       = tr_n_q;
    assign bank_oe    = drive;

    // Every cycle defined; response combined with other blocks here
    assign data_ready  = (state_q == ivas_pkg::ST_RDY) ||
                         (kind_q == ivas_pkg::KIND_WRITE &&
                          ((state_q == ivas_pkg::ST_COL && !write_slow) ||
                           state_q == ivas_pkg::ST_WAIT));
    assign instr_ready = |drive;
    assign resp_out    = data_ready || instr_ready || resp_in;

    ////////////////////////////////////////////////////////////////////////////
    chk_decode_load : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_IDLE && req_valid && !req_sel) |=> ras_n)
        else $error("row strobe loaded for unselected address");
    chk_mux_after_ras : assert property (@(posedge clock) disable iff (rst)
        mux_col |-> !ras_copy_n)
        else $error("mux switched to column without row strobe");
    chk_col_next : assert property (@(posedge clock) disable iff (rst)
        ($fell(ras_n) && kind_q != ivas_pkg::KIND_INSTR) |=> !cas_n)
        else $error("column strobe not in cycle after row cycle");
    chk_read_five : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_IDLE && accept && !req_write && !req_instr)
        |-> !data_ready [*4] ##1 data_ready)
        else $error("data read not five cycles");
    chk_read_gap : assert property (@(posedge clock) disable iff (rst)
        ($fell(cas_n) && kind_q == ivas_pkg::KIND_READ) |-> !data_ready ##1 !data_ready ##1 data_ready)
        else $error("read ready not two cycles after column state");
    chk_write_ready : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_IDLE && accept && req_write && !req_instr) |-> ##[2:3] data_ready)
        else $error("write ready late");
    chk_pc2_read : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_PRE && pc_q == 3'h2 && accept && !req_write && !req_instr)
        |-> ##5 data_ready)
        else $error("read from second precharge not six cycles");
    chk_pre_write : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_PRE && accept && !req_instr) |-> ##[2:7] data_ready)
        else $error("access after precharge too long");
    chk_instr_six : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_IDLE && accept && req_instr) |-> !instr_ready [*5] ##1 instr_ready)
        else $error("initial instruction access not six cycles");
    chk_bank_alt : assert property (@(posedge clock) disable iff (rst)
        (state_q == ivas_pkg::ST_BURST && req_burst) |=> (instr_ready && (serial_shift_clock[0] != serial_shift_clock[1])))
        else $error("burst banks not alternating");
    chk_resp_or : assert property (@(posedge clock) disable iff (rst)
        resp_in |-> resp_out)
        else $error("other block response lost");

endmodule : ivas_seq
